// ===== dsicfg_defs.svh
// Purpose: Constants for the per-channel configuration and check registers.
// Assumes: Registers are reached through a decoded SPI register port.
// Notes: Group codes select a 24-bit register made of the 2nd, 3rd and 4th SPI bytes.
// Functional notes
// - Two-bit chip duration select: 00 3.0us, 01 3.5us, 10 4.0us, 11 4.5us; resets 00.
// - Four-bit expected source id per slave; lower address in bits 15 to 12.
// - Each stored source id is the CRC seed for that slave's responses.
// - Writing 0xFF to a channel clear byte resets every register of that channel.
// - Inverted check pattern register reads 0xAA in all three bytes.
// - Check pattern register reads 0x55 in all three bytes.
// - Eight-bit read-only byte reports the silicon revision.
// - Periodic collection mode is left only by the channel clear write or by reset.
`ifndef DSICFG_DEFS_SVH
`define DSICFG_DEFS_SVH

`define DSICFG_GRP_PERIODIC_COLLECTION_MODE_CTRL   3'h0
`define DSICFG_GRP_PERIODIC_COLLECTION_MODE_CFG    3'h1
`define DSICFG_GRP_CLEAR       3'h2
`define DSICFG_GRP_INV_PATTERN 3'h3
`define DSICFG_GRP_PATTERN     3'h4
`define DSICFG_GRP_REVISION    3'h5

`define DSICFG_BYTE2_MSB       23
`define DSICFG_BYTE2_LSB       16
`define DSICFG_BYTE3_MSB       15
`define DSICFG_BYTE3_LSB       8
`define DSICFG_BYTE4_MSB       7
`define DSICFG_BYTE4_LSB       0

`define DSICFG_PCE_BIT         18
`define DSICFG_CHIP_MSB        17
`define DSICFG_CHIP_LSB        16

`define DSICFG_CHIP_RESET      2'h0
`define DSICFG_SID_RESET       4'h0
`define DSICFG_CLEAR_RESET     8'h00
`define DSICFG_CLEAR_CODE      8'hff
`define DSICFG_INV_PATTERN     8'haa
`define DSICFG_PATTERN         8'h55
`define DSICFG_REVISION        8'h3c

`endif

// ===== dsicfg_pkg.sv
// Purpose: Types shared by the configuration register block.
// Assumes: Two channels, four slaves per channel.
// Notes: Channel state is held as one packed record per channel.
package dsicfg_pkg;

  typedef logic [1:0] dsicfg_chip_type;
  typedef logic [3:0] dsicfg_sid_type;

  typedef struct packed {
    logic                   pce;
    dsicfg_chip_type        chip;
    dsicfg_sid_type [3:0]   sid;
    logic [7:0]             clr;
  } dsicfg_chan_type;

  typedef struct packed {
    dsicfg_chan_type [1:0]  chan;
    logic [23:0]            rdata;
    logic                   rvalid;
  } dsicfg_state_type;

endpackage

// ===== dsicfg_regs.sv
// Purpose: Per-channel configuration registers, check patterns and revision byte.
// Assumes: The SPI engine presents one-cycle read and write strobes on mclk_i.
// Notes: Read data appears one cycle after the read strobe and stands until the next read.
`timescale 1ns/1ps
`include "dsicfg_defs.svh"

module dsicfg_regs #(
  parameter logic [7:0] REVISION = `DSICFG_REVISION  // Arbitrary value.
) (
  input  wire logic                      mclk_i,
  input  wire logic                      resetn_i,
  input  wire logic                      reg_wr_i,
  input  wire logic                      reg_rd_i,
  input  wire logic                      reg_chan_i,
  input  wire logic [2:0]                reg_grp_i,
  input  wire logic [23:0]               reg_wdata_i,
  output logic      [23:0]               reg_rdata_o,
  output logic                           reg_rvalid_o,
  output dsicfg_pkg::dsicfg_chip_type    chip_duration_select_o [2],
  output dsicfg_pkg::dsicfg_sid_type     expected_source_id_o   [2][4],
  output logic      [1:0]                periodic_collection_enable_o
);
  import dsicfg_pkg::*;

  logic             rst_meta_q;
  logic             rst_sync_q;
  dsicfg_state_type state_q;
  dsicfg_state_type state_d;
  dsicfg_chan_type  chan_reset;

  // Reset is released through two flops so that all state leaves reset on one edge.
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  always_comb begin
    chan_reset.pce  = 1'b0;
    chan_reset.chip = `DSICFG_CHIP_RESET;
    chan_reset.sid  = {4{`DSICFG_SID_RESET}};
    chan_reset.clr  = `DSICFG_CLEAR_RESET;
  end

  always_comb begin
    dsicfg_chan_type sel;
    sel     = state_q.chan[reg_chan_i];
    state_d = state_q;
    if (reg_wr_i) begin
      unique case (reg_grp_i)
        `DSICFG_GRP_PERIODIC_COLLECTION_MODE_CTRL: begin
          // Software can only set the enable; clearing it takes the channel clear.
          if (reg_wdata_i[`DSICFG_PCE_BIT]) begin
            state_d.chan[reg_chan_i].pce = 1'b1;
          end
        end
        `DSICFG_GRP_PERIODIC_COLLECTION_MODE_CFG: begin
          // Configuration is frozen while periodic collection runs.
          if (!sel.pce) begin
            state_d.chan[reg_chan_i].chip   = reg_wdata_i[`DSICFG_CHIP_MSB:`DSICFG_CHIP_LSB];
            state_d.chan[reg_chan_i].sid[0] = reg_wdata_i[15:12];
            state_d.chan[reg_chan_i].sid[1] = reg_wdata_i[11:8];
            state_d.chan[reg_chan_i].sid[2] = reg_wdata_i[7:4];
            state_d.chan[reg_chan_i].sid[3] = reg_wdata_i[3:0];
          end
        end
        `DSICFG_GRP_CLEAR: begin
          if (reg_wdata_i[`DSICFG_BYTE2_MSB:`DSICFG_BYTE2_LSB] == `DSICFG_CLEAR_CODE) begin
            state_d.chan[reg_chan_i] = chan_reset;
          end else begin
            state_d.chan[reg_chan_i].clr = reg_wdata_i[`DSICFG_BYTE2_MSB:`DSICFG_BYTE2_LSB];
          end
        end
        default: begin
          // Pattern, revision and unmapped groups take no write.
          state_d = state_q;
        end
      endcase
    end
    state_d.rvalid = reg_rd_i;
    if (reg_rd_i) begin
      unique case (reg_grp_i)
        `DSICFG_GRP_PERIODIC_COLLECTION_MODE_CTRL: begin
          state_d.rdata = {5'h00, sel.pce, 18'h00000};
        end
        `DSICFG_GRP_PERIODIC_COLLECTION_MODE_CFG: begin
          state_d.rdata = {6'h00, sel.chip, sel.sid[0], sel.sid[1], sel.sid[2], sel.sid[3]};
        end
        `DSICFG_GRP_CLEAR: begin
          state_d.rdata = {sel.clr, 16'h0000};
        end
        `DSICFG_GRP_INV_PATTERN: begin
          state_d.rdata = {3{`DSICFG_INV_PATTERN}};
        end
        `DSICFG_GRP_PATTERN: begin
          state_d.rdata = {3{`DSICFG_PATTERN}};
        end
        `DSICFG_GRP_REVISION: begin
          state_d.rdata = {REVISION, 16'h0000};
        end
        default: begin
          state_d.rdata = 24'h000000;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      state_q.chan[0] <= '{pce: 1'b0, chip: `DSICFG_CHIP_RESET, sid: {4{`DSICFG_SID_RESET}}, clr: `DSICFG_CLEAR_RESET};
      state_q.chan[1] <= '{pce: 1'b0, chip: `DSICFG_CHIP_RESET, sid: {4{`DSICFG_SID_RESET}}, clr: `DSICFG_CLEAR_RESET};
      state_q.rdata   <= 24'h000000;
      state_q.rvalid  <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  assign reg_rdata_o  = state_q.rdata;
  assign reg_rvalid_o = state_q.rvalid;

  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_chan
      assign chip_duration_select_o[c]       = state_q.chan[c].chip;
      assign periodic_collection_enable_o[c] = state_q.chan[c].pce;
      assign expected_source_id_o[c][0]      = state_q.chan[c].sid[0];
      assign expected_source_id_o[c][1]      = state_q.chan[c].sid[1];
      assign expected_source_id_o[c][2]      = state_q.chan[c].sid[2];
      assign expected_source_id_o[c][3]      = state_q.chan[c].sid[3];
    end
  endgenerate

endmodule

// ===== dsicfg_regs_properties.sv
// Purpose: Port checks for the channel register block.
// Assumes: One strobe per cycle.
// Notes: Bound to dsicfg_regs.
`timescale 1ns/1ps
module dsicfg_regs_properties
  import dsicfg_pkg::*;
#(
  parameter logic [7:0] REVISION = 8'h00
) (
  input wire logic            mclk_i,
  input wire logic            resetn_i,
  input wire logic            reg_wr_i,
  input wire logic            reg_rd_i,
  input wire logic            reg_chan_i,
  input wire logic [2:0]      reg_grp_i,
  input wire logic [23:0]     reg_wdata_i,
  input wire logic [23:0]     reg_rdata_o,
  input wire logic            reg_rvalid_o,
  input wire dsicfg_chip_type chip_duration_select_o [2],
  input wire dsicfg_sid_type  expected_source_id_o [2][4],
  input wire logic [1:0]      periodic_collection_enable_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  logic        c_q;
  logic [23:0] d_q;
  wire         cfg = reg_wr_i && reg_grp_i == 3'h1;
  wire         pe  = periodic_collection_enable_o[reg_chan_i];
  wire         clr0 = reg_wr_i && reg_grp_i == 3'h2 && reg_wdata_i[23:16] == 8'hff && !reg_chan_i;
  always_ff @(posedge mclk_i) begin
    c_q <= reg_chan_i;
    d_q <= reg_wdata_i;
  end
  sequence s_read(g);
    reg_rd_i && reg_grp_i == g;
  endsequence
  sequence s_clear;
    reg_wr_i && reg_grp_i == 3'h2 && reg_wdata_i[23:16] == 8'hff;
  endsequence
  chk_inv_pattern: assert property (s_read(3'h3) |=> reg_rvalid_o && reg_rdata_o == 24'haaaaaa)
    else $error("bad inverted pattern");
  chk_fixed_pattern: assert property (s_read(3'h4) |=> reg_rdata_o == 24'h555555)
    else $error("bad pattern");
  chk_revision_read: assert property (s_read(3'h5) |=> reg_rdata_o == {REVISION, 16'h0000})
    else $error("bad revision");
  chk_chip_write: assert property (cfg && !pe |=> chip_duration_select_o[c_q] == d_q[17:16])
    else $error("bad chip code");
  chk_sid_order: assert property (cfg && !pe |=> expected_source_id_o[c_q][0] == d_q[15:12]
    && expected_source_id_o[c_q][3] == d_q[3:0]) else $error("bad source id");
  chk_clear_all: assert property (s_clear |=> chip_duration_select_o[c_q] == 2'h0
    && expected_source_id_o[c_q][1] == 4'h0 && !periodic_collection_enable_o[c_q]) else $error("clear missed");
  chk_mode_exit: assert property ($fell(periodic_collection_enable_o[0]) |-> $past(clr0))
    else $error("mode left without clear");
  chk_cfg_freeze: assert property (cfg && pe |=> chip_duration_select_o[c_q] == $past(chip_duration_select_o[reg_chan_i]))
    else $error("config changed in mode");
endmodule

bind dsicfg_regs dsicfg_regs_properties #(.REVISION(REVISION)) i_dsicfg_regs_properties (.mclk_i, .resetn_i, .reg_wr_i,
  .reg_rd_i, .reg_chan_i, .reg_grp_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .chip_duration_select_o,
  .expected_source_id_o, .periodic_collection_enable_o);

// ===== dsicfg_host.sv
// Purpose: Host model that issues one-cycle register strobes.
// Assumes: Called from the bench between clock edges.
// Notes: A read and a write are never issued together.
`timescale 1ns/1ps
module dsicfg_host (
  input  wire logic   mclk_i,
  output logic        wr_o,
  output logic        rd_o,
  output logic        chan_o,
  output logic [2:0]  grp_o,
  output logic [23:0] wdata_o
);
  initial {wr_o, rd_o, chan_o, grp_o, wdata_o} = '0;
  task automatic acc(input logic w, input logic c, input logic [2:0] g, input logic [23:0] d);
    @(posedge mclk_i);
    wr_o <= w;
    rd_o <= !w;
    chan_o <= c;
    grp_o <= g;
    wdata_o <= d;
    @(posedge mclk_i);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
  endtask
endmodule

// ===== dsicfg_regs_tb.sv
// Purpose: Self-checking bench for the channel register block.
// Assumes: Host model drives all strobes.
// Notes: Revision is overridden to a neutral value.
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin failures++; $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module dsicfg_regs_tb;
  import dsicfg_pkg::*;
  logic            mclk_i = 1'b0, resetn_i = 1'b0, reg_wr_i, reg_rd_i, reg_chan_i, reg_rvalid_o, c;
  logic [2:0]      reg_grp_i;
  logic [23:0]     reg_wdata_i, reg_rdata_o, d;
  logic [1:0]      periodic_collection_enable_o;
  dsicfg_chip_type chip_duration_select_o [2];
  dsicfg_sid_type  expected_source_id_o [2][4];
  int              failures = 0, checked = 0, seed = 32'h8791;
  always #12.5 mclk_i = ~mclk_i;
  dsicfg_host i_dsicfg_host (.mclk_i, .wr_o(reg_wr_i), .rd_o(reg_rd_i), .chan_o(reg_chan_i), .grp_o(reg_grp_i),
    .wdata_o(reg_wdata_i));
  dsicfg_regs #(.REVISION(8'h5a)) i_dsicfg_regs (.mclk_i, .resetn_i, .reg_wr_i, .reg_rd_i, .reg_chan_i, .reg_grp_i,
    .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .chip_duration_select_o, .expected_source_id_o,
    .periodic_collection_enable_o);
  function automatic logic [23:0] fixed_word(input logic [2:0] g);
    return g == 3'h3 ? 24'haaaaaa : g == 3'h4 ? 24'h555555 : g == 3'h5 ? 24'h5a0000 : 24'h0;
  endfunction
  task automatic check_cfg(input logic [17:0] w);
    #1;
    `CHK("chip", w[17:16], chip_duration_select_o[c])
    `CHK("sid", w[15:0], {expected_source_id_o[c][0], expected_source_id_o[c][1], expected_source_id_o[c][2], expected_source_id_o[c][3]})
  endtask
  task automatic summarize();
    if (failures == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge mclk_i);
    failures++;
    summarize();
  end
  initial begin
    repeat (20) @(posedge mclk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    c = 1'b0;
    check_cfg(18'h0);
    for (int i = 0; i < 8; i++) begin
      d = $random(seed);
      d[17:16] = i[1:0];
      c = d[20];
      i_dsicfg_host.acc(1'b1, c, 3'h1, d);
      check_cfg(d[17:0]);
    end
    for (int g = 3; g < 8; g++) begin
      i_dsicfg_host.acc(1'b1, c, g[2:0], $random(seed));
      i_dsicfg_host.acc(1'b0, c, g[2:0], 24'h0);
      #1;
      `CHK("rdata", fixed_word(g[2:0]), reg_rdata_o)
      `CHK("rvalid", 1'b1, reg_rvalid_o)
    end
    i_dsicfg_host.acc(1'b1, c, 3'h2, 24'h7e0000);
    i_dsicfg_host.acc(1'b0, c, 3'h2, 24'h0);
    #1;
    `CHK("clear byte", 24'h7e0000, reg_rdata_o)
    check_cfg(d[17:0]);
    i_dsicfg_host.acc(1'b1, c, 3'h0, 24'h040000);
    i_dsicfg_host.acc(1'b1, c, 3'h1, ~d);
    i_dsicfg_host.acc(1'b1, c, 3'h0, 24'h0);
    check_cfg(d[17:0]);
    `CHK("mode", 1'b1, periodic_collection_enable_o[c])
    i_dsicfg_host.acc(1'b1, c, 3'h2, 24'hff0000);
    check_cfg(18'h0);
    `CHK("mode", 1'b0, periodic_collection_enable_o[c])
    i_dsicfg_host.acc(1'b0, c, 3'h2, 24'h0);
    #1;
    `CHK("clear byte", 24'h000000, reg_rdata_o)
    summarize();
  end
endmodule
